/* File: src/ild_params.svh */
// Register offsets, field positions, widths and reset values of the detector.
`ifndef ILD_PARAMS_SVH
`define ILD_PARAMS_SVH

`define ILD_MANT_W       10
`define ILD_DWELL_W      20
`define ILD_CFG_W        5
`define ILD_ADDR_W       8
`define ILD_HOLD_W       3
`define ILD_HOLD_MAX     7

`define ILD_ADDR_LOW     8'h04
`define ILD_ADDR_HIGH    8'h05
`define ILD_ADDR_DWELL   8'h06
`define ILD_ADDR_CFG     8'h07

`define ILD_CFG_POL      4
`define ILD_CFG_ILV      3
`define ILD_CFG_HOLD_HI  2
`define ILD_CFG_HOLD_LO  0

`define ILD_RST_LOW      10'h000
`define ILD_RST_HIGH     10'h000
`define ILD_RST_DWELL    20'h00000
`define ILD_RST_CFG      5'h00
`define ILD_RST_FLAGP    1'h0
`define ILD_RST_FLAGS    1'h1
`define ILD_DWELL_ONE    20'h00001

`endif

/* File: src/ild_pkg.sv */
// Types shared by the level detector modules.
`include "ild_params.svh"

package ild_pkg;

   typedef enum logic [1:0] {ILD_IDLE, ILD_HIGH, ILD_DWELL} ild_state_t;

   typedef struct packed {
      ild_state_t                 st;
      logic [`ILD_DWELL_W-1:0]    cnt;
   } ild_chan_t;

   typedef struct packed {
      logic [`ILD_MANT_W-1:0]     lower;
      logic [`ILD_MANT_W-1:0]     upper;
      logic [`ILD_DWELL_W-1:0]    dwell;
      logic [`ILD_CFG_W-1:0]      cfg;
      ild_chan_t [1:0]            chan;
      logic [`ILD_DWELL_W-1:0]    rdData;
      logic                       flagP;
      logic                       flagS;
   } ild_regs_t;

endpackage

/* File: src/ild_flag_if.sv */
// Raw detection flags and hold-off setting passed to the delay line.
`timescale 1ns/1ps
`include "ild_params.svh"

interface ild_flag_if;
   logic [1:0]              rawFlag;
   logic [`ILD_HOLD_W-1:0]  holdOff;
   logic [1:0]              delayedFlag;

   modport src (output rawFlag, output holdOff, input delayedFlag);
   modport dly (input rawFlag, input holdOff, output delayedFlag);
endinterface

/* File: src/ild_holdoff_delay.sv */
// Programmable hold-off delay line for the two detection flags.
`timescale 1ns/1ps
`include "ild_params.svh"

module ild_holdoff_delay
   import ild_pkg::*;
#(
   parameter int HOLD_MAX = `ILD_HOLD_MAX
) (
   input  wire logic  clk,
   input  wire logic  nrst,
   ild_flag_if.dly    fi
);

   typedef struct packed {
      logic [HOLD_MAX-1:0][1:0] hist;
   } ild_dly_t;

   ild_dly_t st;
   ild_dly_t next_st;

   always_comb begin
      next_st = st;
      next_st.hist = {st.hist[HOLD_MAX-2:0], fi.rawFlag};
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Tap zero bypasses the line so a hold-off of zero adds no cycle.
   always_comb begin
      if (fi.holdOff == '0) begin
         fi.delayedFlag = fi.rawFlag;
      end else begin
         fi.delayedFlag = st.hist[int'(fi.holdOff) - 1];
      end
   end

   a_hold_bypass: assert property (@(posedge clk) disable iff (!nrst)
      (fi.holdOff == '0) |-> (fi.delayedFlag == fi.rawFlag))
      else $error("zero hold-off does not bypass the delay line");
   a_hold_one: assert property (
      @(posedge clk) disable iff (!nrst)
      (fi.holdOff == 3'h1) |-> (fi.delayedFlag == $past(fi.rawFlag)))
      else $error("hold-off of one is not a single cycle delay");

endmodule

/* File: src/ild_level_detector_b.sv */
// Input port B level detector with thresholds, dwell release and hold-off.
`timescale 1ns/1ps
`include "ild_params.svh"

// How it works
// - Lower threshold met when top ten mantissa bits are at or below it.
// - Indicator goes active when top mantissa bits reach the upper threshold.
// - First low sample after an excursion loads the dwell counter.
// - Rising above lower threshold during dwell reloads and waits again.
// - Indicator releases only after the full dwell time at or below lower.
// - Config bit 4 set makes active indicators low, clear makes them high.
// - Single mode drives primary indicator and secondary as its complement.
// - Interleaved mode routes detection by channel select: low primary.
// - Config bits 2..0 delay the indicators by a programmed hold-off.
module ild_level_detector_b
   import ild_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     nrst,
   input  wire logic [`ILD_MANT_W-1:0]   sampleMant,
   input  wire logic                     portBChannelSelect,
   input  wire logic                     inputPortSpace,
   input  wire logic [`ILD_ADDR_W-1:0]   channelAddressPointer,
   input  wire logic [`ILD_DWELL_W-1:0]  wrData,
   input  wire logic                     wrStrobe,
   input  wire logic                     rdStrobe,
   output logic      [`ILD_DWELL_W-1:0]  rdData,
   output logic                          levelFlagPrimaryB,
   output logic                          levelFlagSecondaryB
);

   ild_regs_t   st;
   ild_regs_t   next_st;
   ild_flag_if  fi ();

   logic        ilv;
   logic        pol;
   logic        chIdx;

   // One sample step of a channel's detector.
   function automatic ild_chan_t chanStep(
      input ild_chan_t              c,
      input logic [`ILD_MANT_W-1:0] s,
      input logic [`ILD_MANT_W-1:0] lo,
      input logic [`ILD_MANT_W-1:0] hi,
      input logic [`ILD_DWELL_W-1:0] dw
   );
      ild_chan_t n;
      n = c;
      case (c.st)
         ILD_IDLE: begin
            if (s >= hi) begin
               n.st = ILD_HIGH;
            end
         end
         ILD_HIGH: begin
            // Upper wins if thresholds are programmed out of order.
            if (s >= hi) begin
               n.st = ILD_HIGH;
            end else if (s <= lo) begin
               if (dw == `ILD_DWELL_ONE) begin
                  n.st = ILD_IDLE;
               end else begin
                  n.st  = ILD_DWELL;
                  n.cnt = dw - `ILD_DWELL_ONE;
               end
            end
         end
         ILD_DWELL: begin
            if (s > lo) begin
               n.st  = ILD_HIGH;
               n.cnt = dw;
            end else if (c.cnt <= `ILD_DWELL_ONE) begin
               n.st = ILD_IDLE;
            end else begin
               n.cnt = c.cnt - `ILD_DWELL_ONE;
            end
         end
         default: begin
            n.st = ILD_IDLE;
         end
      endcase
      return n;
   endfunction

   assign ilv   = st.cfg[`ILD_CFG_ILV];
   assign pol   = st.cfg[`ILD_CFG_POL];
   assign chIdx = ilv & portBChannelSelect;

   assign fi.rawFlag = {st.chan[1].st != ILD_IDLE, st.chan[0].st != ILD_IDLE};
   assign fi.holdOff = st.cfg[`ILD_CFG_HOLD_HI:`ILD_CFG_HOLD_LO];

   ild_holdoff_delay u_delay (
      .clk  (clk),
      .nrst (nrst),
      .fi   (fi.dly)
   );

   always_comb begin
      next_st = st;
      // Register access through the channel address pointer window.
      if (inputPortSpace && wrStrobe) begin
         case (channelAddressPointer)
            `ILD_ADDR_LOW:   next_st.lower = wrData[`ILD_MANT_W-1:0];
            `ILD_ADDR_HIGH:  next_st.upper = wrData[`ILD_MANT_W-1:0];
            `ILD_ADDR_DWELL: next_st.dwell = wrData;
            `ILD_ADDR_CFG:   next_st.cfg   = wrData[`ILD_CFG_W-1:0];
            default:         next_st.cfg   = st.cfg;
         endcase
      end
      // An unmapped read returns zero so software can probe safely.
      if (inputPortSpace && rdStrobe) begin
         case (channelAddressPointer)
            `ILD_ADDR_LOW:   next_st.rdData = {10'h000, st.lower};
            `ILD_ADDR_HIGH:  next_st.rdData = {10'h000, st.upper};
            `ILD_ADDR_DWELL: next_st.rdData = st.dwell;
            `ILD_ADDR_CFG:   next_st.rdData = {15'h0000, st.cfg};
            default:         next_st.rdData = '0;
         endcase
      end

      // Detection uses the settings in force before this cycle's write.
      if (st.dwell == '0) begin
         next_st.chan = '0;
      end else begin
         next_st.chan[chIdx] = chanStep(st.chan[chIdx], sampleMant,
                                        st.lower, st.upper, st.dwell);
         if (!ilv) begin
            next_st.chan[1] = '0;
         end
      end

      next_st.flagP = fi.delayedFlag[0] ^ pol;
      if (ilv) begin
         next_st.flagS = fi.delayedFlag[1] ^ pol;
      end else begin
         next_st.flagS = ~(fi.delayedFlag[0] ^ pol);
      end
   end

   // One packed record holds registers and detector state, so a single
   // reset clears everything together; the secondary resets high so it
   // starts as the complement of an inactive primary.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st        <= '0;
         st.lower  <= `ILD_RST_LOW;
         st.upper  <= `ILD_RST_HIGH;
         st.dwell  <= `ILD_RST_DWELL;
         st.cfg    <= `ILD_RST_CFG;
         st.flagP  <= `ILD_RST_FLAGP;
         st.flagS  <= `ILD_RST_FLAGS;
      end else begin
         st <= next_st;
      end
   end

   assign rdData              = st.rdData;
   assign levelFlagPrimaryB   = st.flagP;
   assign levelFlagSecondaryB = st.flagS;

   // Checks follow channel 0 in single mode and both when interleaved.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_upper_trip: assert property (
      (st.dwell != '0) && !ilv && (st.chan[0].st == ILD_IDLE)
      && (sampleMant >= st.upper) |=> (st.chan[0].st == ILD_HIGH))
      else $error("upper crossing did not activate detection");
   a_lower_load: assert property (
      (st.dwell > `ILD_DWELL_ONE) && !ilv && (st.chan[0].st == ILD_HIGH)
      && (sampleMant < st.upper) && (sampleMant <= st.lower)
      |=> (st.chan[0].st == ILD_DWELL)
          && (st.chan[0].cnt == $past(st.dwell) - `ILD_DWELL_ONE))
      else $error("dwell counter not loaded on lower crossing");
   a_dwell_reload: assert property (
      (st.dwell != '0) && !ilv && (st.chan[0].st == ILD_DWELL)
      && (sampleMant > st.lower) |=> (st.chan[0].st == ILD_HIGH))
      else $error("rise during dwell did not reload");
   a_dwell_release: assert property (
      (st.dwell != '0) && !ilv && (st.chan[0].st == ILD_DWELL)
      && (st.chan[0].cnt > `ILD_DWELL_ONE) && (sampleMant <= st.lower)
      |=> (st.chan[0].st == ILD_DWELL))
      else $error("indicator released before dwell expired");
   a_dwell_disable: assert property (
      (st.dwell == '0) |=> (st.chan == '0))
      else $error("zero dwell did not disable detection");
   a_pol_single: assert property (
      !ilv |=> (levelFlagPrimaryB == ($past(fi.delayedFlag[0]) ^ $past(pol))))
      else $error("primary indicator polarity wrong");
   a_single_compl: assert property (
      !ilv |=> (levelFlagPrimaryB != levelFlagSecondaryB))
      else $error("secondary is not the complement in single mode");
   a_ilv_route: assert property (
      (st.dwell != '0) && ilv && portBChannelSelect
      && (st.chan[1].st == ILD_IDLE) && (sampleMant >= st.upper)
      |=> (st.chan[1].st == ILD_HIGH) && $stable(st.chan[0]))
      else $error("interleaved detection not routed to secondary");
   a_ilv_hold: assert property (
      (st.dwell != '0) && ilv && !portBChannelSelect
      |=> $stable(st.chan[1]))
      else $error("unselected secondary channel changed state");
   a_ilv_pol: assert property (
      ilv |=> (levelFlagSecondaryB
               == ($past(fi.delayedFlag[1]) ^ $past(pol))))
      else $error("secondary indicator polarity wrong");
   a_dwell_count: assert property (
      (st.dwell != '0) && !ilv && (st.chan[0].st == ILD_DWELL)
      && (st.chan[0].cnt > `ILD_DWELL_ONE) && (sampleMant <= st.lower)
      |=> (st.chan[0].cnt == $past(st.chan[0].cnt) - `ILD_DWELL_ONE))
      else $error("dwell counter did not count down");
   a_space_gate: assert property (
      !inputPortSpace |=> $stable(st.lower) && $stable(st.upper)
      && $stable(st.dwell) && $stable(st.cfg))
      else $error("register changed with the window closed");

   c_trip: cover property (
      (st.chan[0].st == ILD_IDLE) ##1 (st.chan[0].st == ILD_HIGH));
   c_release: cover property (
      (st.chan[0].st == ILD_DWELL) ##1 (st.chan[0].st == ILD_IDLE));
   c_reload: cover property (
      (st.chan[0].st == ILD_DWELL) ##1 (st.chan[0].st == ILD_HIGH));
   c_ilv_sec: cover property (ilv && (st.chan[1].st == ILD_HIGH));
   c_ilv_pri: cover property (ilv && (st.chan[0].st == ILD_HIGH));

endmodule

/* File: dv/ild_attenuator_model.sv */
// Behavioural model of the external attenuator ahead of the converter.
`timescale 1ns/1ps
module ild_attenuator_model (
   input  wire logic levelFlag,
   input  wire logic activeLow,
   input  wire logic clk,
   input  wire logic nrst,
   output logic      attenOn
);
   // A real gain stage switches a clock after the flag, never sooner.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         attenOn <= 1'b0;
      end else begin
         attenOn <= levelFlag ^ activeLow;
      end
   end
endmodule

/* File: dv/ild_level_detector_b_tb_top.sv */
// Self-checking bench for the port B level detector.
`timescale 1ns/1ps
`include "ild_params.svh"
module ild_level_detector_b_tb_top;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [9:0]  sampleMant = 10'h000;
   logic        sel = 1'b0;
   logic        space = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [19:0] wrData = 20'h00000;
   logic        wrS = 1'b0;
   logic        rdS = 1'b0;
   logic [19:0] rdData;
   logic        flagP;
   logic        flagS;
   logic        attenOn;
   logic        pol = 1'b0;
   logic        ilv = 1'b0;
   int          failures = 0;
   int          checkCount = 0;
   logic [7:0]  addrs [4] = '{8'h04, 8'h05, 8'h06, 8'h07};
   logic [19:0] masks [4] = '{20'h003ff, 20'h003ff, 20'hfffff, 20'h0001f};

   always #5 clk = ~clk;

   ild_level_detector_b dut_u (
      .clk(clk), .nrst(nrst), .sampleMant(sampleMant),
      .portBChannelSelect(sel), .inputPortSpace(space),
      .channelAddressPointer(addr), .wrData(wrData), .wrStrobe(wrS),
      .rdStrobe(rdS), .rdData(rdData), .levelFlagPrimaryB(flagP),
      .levelFlagSecondaryB(flagS)
   );
   ild_attenuator_model atten_u (
      .levelFlag(flagP), .activeLow(pol), .clk(clk), .nrst(nrst),
      .attenOn(attenOn)
   );

   task automatic test_done;
      $display("checks %0d failures %0d", checkCount, failures);
      if (failures == 0 && checkCount > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      checkCount++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One strobe cycle, then an idle cycle, so a following call never
   // raises a strobe in the same step that this one lowered it.
   task automatic wr(input logic [7:0] a, input logic [19:0] d,
                     input logic sp);
      space = sp;
      addr = a;
      wrData = d;
      wrS = 1'b1;
      @(negedge clk);
      wrS = 1'b0;
      space = 1'b1;
      @(negedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [19:0] exp);
      addr = a;
      rdS = 1'b1;
      @(negedge clk);
      rdS = 1'b0;
      chk(rdData, exp);
      @(negedge clk);
   endtask

   task automatic cfg(input logic p, input logic i, input logic [2:0] h);
      wr(`ILD_ADDR_CFG, {15'h0000, p, i, h}, 1'b1);
      pol = p;
      ilv = i;
      sampleMant = 10'h000;
      repeat (10) @(negedge clk);
   endtask

   // Present one sample, then compare both pins after that edge.
   task automatic step(input logic [9:0] s, input logic aP, input logic aS);
      logic eP;
      logic eS;
      sampleMant = s;
      @(negedge clk);
      eP = aP ^ pol;
      eS = ilv ? (aS ^ pol) : ~eP;
      chk({19'h00000, flagP}, {19'h00000, eP});
      chk({19'h00000, flagS}, {19'h00000, eS});
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      test_done();
   end

   initial begin
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      step(10'h000, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         rd(addrs[i], 20'h00000);
         wr(addrs[i], 20'hfffff, 1'b1);
         rd(addrs[i], masks[i]);
         wr(addrs[i], 20'h00000, 1'b0);
         rd(addrs[i], masks[i]);
      end
      rd(8'h08, 20'h00000);
      wr(8'h08, 20'h00000, 1'b1);
      rd(`ILD_ADDR_CFG, 20'h0001f);
      wr(`ILD_ADDR_LOW, 20'h00100, 1'b1);
      wr(`ILD_ADDR_HIGH, 20'h00300, 1'b1);
      wr(`ILD_ADDR_DWELL, 20'h00000, 1'b1);
      cfg(1'b0, 1'b0, 3'h0);
      repeat (3) step(10'h3ff, 1'b0, 1'b0);
      // Drop the sample before enabling, so the write sees no old peak.
      step(10'h000, 1'b0, 1'b0);
      wr(`ILD_ADDR_DWELL, 20'h00003, 1'b1);
      step(10'h2ff, 1'b0, 1'b0);
      step(10'h300, 1'b0, 1'b0);
      step(10'h100, 1'b1, 1'b0);
      step(10'h100, 1'b1, 1'b0);
      step(10'h101, 1'b1, 1'b0);
      repeat (3) step(10'h100, 1'b1, 1'b0);
      chk({19'h00000, attenOn}, 20'h00001);
      step(10'h100, 1'b0, 1'b0);
      step(10'h000, 1'b0, 1'b0);
      chk({19'h00000, attenOn}, 20'h00000);
      wr(`ILD_ADDR_DWELL, 20'h00001, 1'b1);
      for (int h = 0; h < 8; h++) begin
         cfg(1'b0, 1'b0, h[2:0]);
         repeat (h + 1) step(10'h300, 1'b0, 1'b0);
         step(10'h300, 1'b1, 1'b0);
         repeat (h + 1) step(10'h000, 1'b1, 1'b0);
         step(10'h000, 1'b0, 1'b0);
      end
      cfg(1'b1, 1'b0, 3'h0);
      step(10'h300, 1'b0, 1'b0);
      step(10'h000, 1'b1, 1'b0);
      step(10'h000, 1'b0, 1'b0);
      cfg(1'b0, 1'b1, 3'h0);
      sel = 1'b1;
      step(10'h300, 1'b0, 1'b0);
      step(10'h000, 1'b0, 1'b1);
      sel = 1'b0;
      step(10'h300, 1'b0, 1'b0);
      sel = 1'b1;
      repeat (2) step(10'h000, 1'b1, 1'b0);
      sel = 1'b0;
      step(10'h000, 1'b1, 1'b0);
      step(10'h000, 1'b0, 1'b0);
      cfg(1'b1, 1'b1, 3'h0);
      step(10'h000, 1'b0, 1'b0);
      // A reset in mid-excursion, before the primary rises, must leave the primary low and the secondary high.
      cfg(1'b0, 1'b0, 3'h0);
      step(10'h300, 1'b0, 1'b0);
      nrst = 1'b0;
      @(negedge clk);
      chk({18'h00000, flagP, flagS}, 20'h00001);
      nrst = 1'b1;
      rd(`ILD_ADDR_DWELL, 20'h00000);
      test_done();
   end
endmodule
